// ==== src/fts_pkg.sv ====
`default_nettype none
package fts_pkg;
   // Register byte addresses (index times four; 0xD9 is not a multiple of four)
   localparam logic [7:0] IDX_BOUNDARY = 8'hD9;
   localparam logic [7:0] IDX_SEG1 = 8'hDA;
   localparam logic [7:0] IDX_SEG2 = 8'hDB;
   localparam logic [7:0] IDX_SEG3 = 8'hDC;
   localparam logic [7:0] IDX_SEG4 = 8'hDD;
   localparam logic [7:0] IDX_SEG5 = 8'hDE;
   localparam logic [7:0] IDX_CTRL = 8'hE0;
   localparam logic [7:0] IDX_STATUS = 8'hE1;
   localparam logic [11:0] ADDR_BOUNDARY = {2'h0, IDX_BOUNDARY, 2'h0};
   localparam logic [11:0] ADDR_SEG1 = {2'h0, IDX_SEG1, 2'h0};
   localparam logic [11:0] ADDR_SEG2 = {2'h0, IDX_SEG2, 2'h0};
   localparam logic [11:0] ADDR_SEG3 = {2'h0, IDX_SEG3, 2'h0};
   localparam logic [11:0] ADDR_SEG4 = {2'h0, IDX_SEG4, 2'h0};
   localparam logic [11:0] ADDR_SEG5 = {2'h0, IDX_SEG5, 2'h0};
   localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   // Field layout
   localparam int BOUND_MSB = 6;
   localparam int HYST_MSB = 3;
   localparam int MODE_LSB = 4;
   // Reset values
   localparam logic [6:0] RST_BOUNDARY = 7'h1E;
   localparam logic [7:0] RST_SEG1 = 8'h00;
   localparam logic [7:0] RST_SEG2 = 8'h00;
   localparam logic [7:0] RST_SEG3 = 8'h00;
   localparam logic [7:0] RST_SEG4 = 8'h99;
   localparam logic [7:0] RST_SEG5 = 8'h80;
   localparam logic [3:0] RST_HYST = 4'h4;
   localparam logic [1:0] RST_MODE = 2'h0;
   // Target interpretation
   typedef enum logic [1:0] {
      FTS_MODE_SPEED = 2'b00,
      FTS_MODE_DUTY = 2'b01,
      FTS_MODE_RSV2 = 2'b10,
      FTS_MODE_RSV3 = 2'b11
   } fts_mode_t;
   // Segment choice around the fourth boundary
   typedef enum logic {
      FTS_SEL_SEG5 = 1'b0,
      FTS_SEL_SEG4 = 1'b1
   } fts_sel_t;
   // Expected value handed to the fan driver
   typedef struct packed {
      logic [7:0] value;
      logic is_duty;
      logic full_speed;
      logic valid;
   } fts_expect_t;
endpackage
`default_nettype wire

// ==== src/fts_segment_table.sv ====
// Summary of operation
// - Temperature above fourth boundary loads expected value from segment four target.
// - Temperature below boundary minus hysteresis loads expected value from segment five.
// - Mode 2'b00 treats each target byte as relative fan speed.
// - Mode 2'b01 treats each target byte directly as PWM duty.
// - In speed mode, target zero means full speed.
//
// Design decision made here: register access over APB.
`default_nettype none
module fts_segment_table (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Temperature and fan
   input wire logic [6:0] fourth_temp_input,
   output fts_pkg::fts_expect_t fourth_fan_output
);

   logic [6:0] fourth_boundary_value_reg;
   logic [7:0] segment_one_target_reg;
   logic [7:0] segment_two_target_reg;
   logic [7:0] segment_three_target_reg;
   logic [7:0] segment_four_target_reg;
   logic [7:0] segment_five_target_reg;
   logic [3:0] hyst_reg;
   logic [1:0] fan_target_interpretation_reg;
   fts_pkg::fts_sel_t sel_reg;
   fts_pkg::fts_sel_t sel_next;
   fts_pkg::fts_expect_t expect_reg;
   fts_pkg::fts_expect_t expect_next;

   // Bus decode
   wire logic wr_en = psel && penable && pwrite;
   wire logic rd_en = psel && penable && !pwrite;
   wire logic rd_setup = psel && !penable && !pwrite;
   wire logic hit_bound = (paddr == fts_pkg::ADDR_BOUNDARY);
   wire logic hit_seg1 = (paddr == fts_pkg::ADDR_SEG1);
   wire logic hit_seg2 = (paddr == fts_pkg::ADDR_SEG2);
   wire logic hit_seg3 = (paddr == fts_pkg::ADDR_SEG3);
   wire logic hit_seg4 = (paddr == fts_pkg::ADDR_SEG4);
   wire logic hit_seg5 = (paddr == fts_pkg::ADDR_SEG5);
   wire logic hit_ctrl = (paddr == fts_pkg::ADDR_CTRL);
   wire logic hit_stat = (paddr == fts_pkg::ADDR_STATUS);
   wire logic hit_any = hit_bound | hit_seg1 | hit_seg2 | hit_seg3 | hit_seg4 | hit_seg5 | hit_ctrl | hit_stat;

   // Zero-wait answer; unmapped addresses raise pslverr
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit_any;

   // Read mux; reserved bits read zero
   wire logic [31:0] rd_mux =
      hit_bound ? {25'h0, fourth_boundary_value_reg} :
      hit_seg1 ? {24'h0, segment_one_target_reg} :
      hit_seg2 ? {24'h0, segment_two_target_reg} :
      hit_seg3 ? {24'h0, segment_three_target_reg} :
      hit_seg4 ? {24'h0, segment_four_target_reg} :
      hit_seg5 ? {24'h0, segment_five_target_reg} :
      hit_ctrl ? {26'h0, fan_target_interpretation_reg, hyst_reg} :
      hit_stat ? {22'h0, expect_reg.value, 1'b0, sel_reg} :
      32'h0000_0000;

   // Read data register; loaded in the setup cycle so it stands through the zero-wait access cycle
   // A status read therefore shows the state of the setup cycle, one cycle before the access cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // Read data stands with pready in the access cycle; reserved bits read zero
   property p_read_bound;
      @(posedge clock) disable iff (!rst_n)
      rd_en && hit_bound |-> prdata == {25'h0, fourth_boundary_value_reg};
   endproperty
   a_read_bound: assert property (p_read_bound) else $error("boundary read data wrong");

   property p_read_seg1;
      @(posedge clock) disable iff (!rst_n)
      rd_en && hit_seg1 |-> prdata == {24'h0, segment_one_target_reg};
   endproperty
   a_read_seg1: assert property (p_read_seg1) else $error("segment one read data wrong");

   property p_read_seg4;
      @(posedge clock) disable iff (!rst_n)
      rd_en && hit_seg4 |-> prdata == {24'h0, segment_four_target_reg};
   endproperty
   a_read_seg4: assert property (p_read_seg4) else $error("segment four read data wrong");

   // Writable registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fourth_boundary_value_reg <= fts_pkg::RST_BOUNDARY;
         segment_one_target_reg <= fts_pkg::RST_SEG1;
         segment_two_target_reg <= fts_pkg::RST_SEG2;
         segment_three_target_reg <= fts_pkg::RST_SEG3;
         segment_four_target_reg <= fts_pkg::RST_SEG4;
         segment_five_target_reg <= fts_pkg::RST_SEG5;
         hyst_reg <= fts_pkg::RST_HYST;
         fan_target_interpretation_reg <= fts_pkg::RST_MODE;
      end else if (wr_en) begin
         if (hit_bound) fourth_boundary_value_reg <= pwdata[fts_pkg::BOUND_MSB:0];
         if (hit_seg1) segment_one_target_reg <= pwdata[7:0];
         if (hit_seg2) segment_two_target_reg <= pwdata[7:0];
         if (hit_seg3) segment_three_target_reg <= pwdata[7:0];
         if (hit_seg4) segment_four_target_reg <= pwdata[7:0];
         if (hit_seg5) segment_five_target_reg <= pwdata[7:0];
         if (hit_ctrl) begin
            hyst_reg <= pwdata[fts_pkg::HYST_MSB:0];
            fan_target_interpretation_reg <= pwdata[fts_pkg::MODE_LSB +: 2];
         end
      end
   end

   // Write data fields as each register takes them, for the checks that follow
   wire logic [7:0] wr_byte = pwdata[7:0];
   wire logic [6:0] wr_bound = pwdata[fts_pkg::BOUND_MSB:0];
   wire logic [5:0] wr_ctrl = pwdata[fts_pkg::MODE_LSB + 1:0];

   // A register takes the write data at the access edge and holds otherwise
   property p_bound_write;
      @(posedge clock) disable iff (!rst_n)
      rst_n && wr_en && hit_bound |=> fourth_boundary_value_reg == $past(wr_bound);
   endproperty
   a_bound_write: assert property (p_bound_write) else $error("boundary write lost");

   property p_bound_hold;
      @(posedge clock) disable iff (!rst_n)
      rst_n && !(wr_en && hit_bound) |=> $stable(fourth_boundary_value_reg);
   endproperty
   a_bound_hold: assert property (p_bound_hold) else $error("boundary changed without write");

   property p_seg1_hold;
      @(posedge clock) disable iff (!rst_n)
      rst_n && !(wr_en && hit_seg1) |=> $stable(segment_one_target_reg);
   endproperty
   a_seg1_hold: assert property (p_seg1_hold) else $error("segment one changed without write");

   property p_seg2_hold;
      @(posedge clock) disable iff (!rst_n)
      rst_n && !(wr_en && hit_seg2) |=> $stable(segment_two_target_reg);
   endproperty
   a_seg2_hold: assert property (p_seg2_hold) else $error("segment two changed without write");

   property p_seg3_hold;
      @(posedge clock) disable iff (!rst_n)
      rst_n && !(wr_en && hit_seg3) |=> $stable(segment_three_target_reg);
   endproperty
   a_seg3_hold: assert property (p_seg3_hold) else $error("segment three changed without write");

   property p_seg4_write;
      @(posedge clock) disable iff (!rst_n)
      rst_n && wr_en && hit_seg4 |=> segment_four_target_reg == $past(wr_byte);
   endproperty
   a_seg4_write: assert property (p_seg4_write) else $error("segment four write lost");

   property p_seg4_hold;
      @(posedge clock) disable iff (!rst_n)
      rst_n && !(wr_en && hit_seg4) |=> $stable(segment_four_target_reg);
   endproperty
   a_seg4_hold: assert property (p_seg4_hold) else $error("segment four changed without write");

   property p_seg5_hold;
      @(posedge clock) disable iff (!rst_n)
      rst_n && !(wr_en && hit_seg5) |=> $stable(segment_five_target_reg);
   endproperty
   a_seg5_hold: assert property (p_seg5_hold) else $error("segment five changed without write");

   property p_ctrl_write;
      @(posedge clock) disable iff (!rst_n)
      rst_n && wr_en && hit_ctrl |=> {fan_target_interpretation_reg, hyst_reg} == $past(wr_ctrl);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   // Threshold compare; low threshold floors at zero
   wire logic [7:0] low_wide = {1'b0, fourth_boundary_value_reg} - {4'h0, hyst_reg};
   wire logic [6:0] low_thr = low_wide[7] ? 7'h00 : low_wide[6:0];
   wire logic above = fourth_temp_input > fourth_boundary_value_reg;
   wire logic below = fourth_temp_input < low_thr;

   // Segment selection with hysteresis
   always_comb begin
      sel_next = sel_reg;
      if (above) begin
         sel_next = fts_pkg::FTS_SEL_SEG4;
      end else if (below) begin
         sel_next = fts_pkg::FTS_SEL_SEG5;
      end
   end

   // Interpretation of the chosen target byte
   wire logic [7:0] chosen = (sel_next == fts_pkg::FTS_SEL_SEG4) ? segment_four_target_reg : segment_five_target_reg;
   wire logic mode_duty = (fan_target_interpretation_reg == fts_pkg::FTS_MODE_DUTY);
   wire logic mode_speed = (fan_target_interpretation_reg == fts_pkg::FTS_MODE_SPEED);

   // Build expected value
   always_comb begin
      expect_next.value = chosen;
      expect_next.is_duty = mode_duty;
      expect_next.full_speed = mode_speed && (chosen == 8'h00);
      expect_next.valid = mode_speed || mode_duty;
   end

   // Selection and output registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sel_reg <= fts_pkg::FTS_SEL_SEG5;
         expect_reg <= '0;
      end else begin
         sel_reg <= sel_next;
         expect_reg <= expect_next;
      end
   end

   // Expected value goes straight from its register to the fan driver
   assign fourth_fan_output = expect_reg;

   // Checks
   property p_load_seg4;
      @(posedge clock) disable iff (!rst_n)
      rst_n && (fourth_temp_input > fourth_boundary_value_reg) |=> (sel_reg == fts_pkg::FTS_SEL_SEG4)
         && (fourth_fan_output.value == $past(segment_four_target_reg));
   endproperty
   a_load_seg4: assert property (p_load_seg4) else $error("segment four not loaded");

   property p_load_seg5;
      @(posedge clock) disable iff (!rst_n)
      rst_n && (fourth_temp_input < low_thr) |=> (sel_reg == fts_pkg::FTS_SEL_SEG5)
         && (fourth_fan_output.value == $past(segment_five_target_reg));
   endproperty
   a_load_seg5: assert property (p_load_seg5) else $error("segment five not loaded");

   property p_speed_mode;
      @(posedge clock) disable iff (!rst_n)
      rst_n && (fan_target_interpretation_reg == fts_pkg::FTS_MODE_SPEED)
         |=> fourth_fan_output.valid && !fourth_fan_output.is_duty;
   endproperty
   a_speed_mode: assert property (p_speed_mode) else $error("speed mode not flagged");

   property p_duty_mode;
      @(posedge clock) disable iff (!rst_n)
      rst_n && (fan_target_interpretation_reg == fts_pkg::FTS_MODE_DUTY)
         |=> fourth_fan_output.valid && fourth_fan_output.is_duty && !fourth_fan_output.full_speed;
   endproperty
   a_duty_mode: assert property (p_duty_mode) else $error("duty mode not flagged");

   property p_full_speed;
      @(posedge clock) disable iff (!rst_n)
      fourth_fan_output.full_speed |-> fourth_fan_output.value == 8'h00 && !fourth_fan_output.is_duty;
   endproperty
   a_full_speed: assert property (p_full_speed) else $error("full speed without zero target");

   property p_hold;
      @(posedge clock) disable iff (!rst_n)
      rst_n && !(fourth_temp_input > fourth_boundary_value_reg) && !(fourth_temp_input < low_thr)
         |=> $stable(sel_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("segment toggled inside band");

   // Reserved mode codes flag the output as not valid
   property p_invalid_mode;
      @(posedge clock) disable iff (!rst_n)
      rst_n && fan_target_interpretation_reg[1]
         |=> !fourth_fan_output.valid && !fourth_fan_output.is_duty && !fourth_fan_output.full_speed;
   endproperty
   a_invalid_mode: assert property (p_invalid_mode) else $error("reserved mode flagged valid");

   // Only a crossing of the boundary or of the low threshold moves the selection
   property p_stay_seg5;
      @(posedge clock) disable iff (!rst_n)
      rst_n && (sel_reg == fts_pkg::FTS_SEL_SEG5) && !(fourth_temp_input > fourth_boundary_value_reg)
         |=> (sel_reg == fts_pkg::FTS_SEL_SEG5);
   endproperty
   a_stay_seg5: assert property (p_stay_seg5) else $error("segment five left without crossing");

   property p_stay_seg4;
      @(posedge clock) disable iff (!rst_n)
      rst_n && (sel_reg == fts_pkg::FTS_SEL_SEG4) && !(fourth_temp_input < low_thr)
         |=> (sel_reg == fts_pkg::FTS_SEL_SEG4);
   endproperty
   a_stay_seg4: assert property (p_stay_seg4) else $error("segment four left without crossing");

   property p_full_speed_set;
      @(posedge clock) disable iff (!rst_n)
      fourth_fan_output.valid && !fourth_fan_output.is_duty && (fourth_fan_output.value == 8'h00)
         |-> fourth_fan_output.full_speed;
   endproperty
   a_full_speed_set: assert property (p_full_speed_set) else $error("zero target not full speed");

   // Reset clears the output and the read data and selects segment five
   property p_reset_state;
      @(posedge clock)
      !rst_n |=> (fourth_fan_output == '0) && (sel_reg == fts_pkg::FTS_SEL_SEG5) && (prdata == 32'h0000_0000);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

endmodule // fts_segment_table
`default_nettype wire

// ==== tb/fts_temp_source.sv ====
`default_nettype none
// Temperature sensor stand-in: a new reading appears one clock after it is requested
module fts_temp_source (
   // Clock
   input wire logic clock,
   // Requested and measured temperature
   input wire logic [6:0] want,
   output logic [6:0] temp
);
   timeunit 1ns;
   timeprecision 1ps;
   // Measurement lag of one cycle, like a sampled sensor
   always_ff @(posedge clock) begin
      temp <= want;
   end
endmodule // fts_temp_source
`default_nettype wire

// ==== tb/tb_fts_segment_table.sv ====
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_fts_segment_table;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [6:0] want = 7'h00, temp;
   fts_pkg::fts_expect_t fourth_fan_output;
   int bad_count = 0, n_checks = 0;
   // Sixty percent encoded for speed mode
   localparam logic [7:0] SPEED60 = 8'((100 - 60) * 32 / 60);
   fts_segment_table uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fourth_temp_input(temp), .fourth_fan_output(fourth_fan_output));
   fts_temp_source sensor (.clock(clock), .want(want), .temp(temp));
   // Clock source
   initial begin
      forever #5 clock = ~clock;
   end
   // One APB transfer; the answer is taken at the edge where pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   // Read one register and compare
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(q, e)
   endtask
   // Move the temperature and let it reach the output
   task automatic heat(input logic [6:0] t);
      want <= t;
      repeat (4) @(posedge clock);
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Watchdog well beyond the fewer than one hundred cycles the tests need
   initial begin
      #50000;
      bad_count++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(fts_pkg::ADDR_BOUNDARY, 32'h0000_001E);
      rd(fts_pkg::ADDR_SEG4, 32'h0000_0099);
      rd(fts_pkg::ADDR_SEG1, 32'h0000_0000);
      rd(fts_pkg::ADDR_CTRL, 32'h0000_0004);
      // Boundary top bit is reserved and reads zero
      apb(1'b1, fts_pkg::ADDR_BOUNDARY, 32'h0000_00FF);
      rd(fts_pkg::ADDR_BOUNDARY, 32'h0000_007F);
      apb(1'b1, fts_pkg::ADDR_BOUNDARY, 32'h0000_001E);
      // Unmapped address is refused
      rd(12'h000, 32'h0000_0000);
      `CHK(err, 1'b1)
      // Segment choice around boundary 30 with hysteresis 4
      apb(1'b1, fts_pkg::ADDR_SEG4, {24'h0, SPEED60});
      rd(fts_pkg::ADDR_SEG4, 32'h0000_0015);
      heat(7'd31);
      `CHK(fourth_fan_output, {SPEED60, 1'b0, 1'b0, 1'b1})
      rd(fts_pkg::ADDR_STATUS, {22'h0, SPEED60, 2'h1});
      heat(7'd30);
      `CHK(fourth_fan_output, {SPEED60, 1'b0, 1'b0, 1'b1})
      heat(7'd26);
      `CHK(fourth_fan_output, {SPEED60, 1'b0, 1'b0, 1'b1})
      heat(7'd25);
      `CHK(fourth_fan_output, {8'h80, 1'b0, 1'b0, 1'b1})
      heat(7'd30);
      `CHK(fourth_fan_output, {8'h80, 1'b0, 1'b0, 1'b1})
      // Zero target under every mode code
      apb(1'b1, fts_pkg::ADDR_SEG4, 32'h0000_0000);
      heat(7'd31);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, fts_pkg::ADDR_CTRL, {26'h0, 2'(m), 4'h4});
         repeat (2) @(posedge clock);
         `CHK(fourth_fan_output, {8'h00, m == 1, m == 0, m < 2})
      end
      finish_test();
   end
endmodule // tb_fts_segment_table
`undef CHK
`default_nettype wire
